// File: hw/ckc_clock_ctrl.sv
// Clock output enable, power-down reset and spread control with an APB register slave
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "ckc_regs.svh"

module ckc_clock_ctrl (
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Device pins in
   input wire logic global_powerdown_reset_n,
   input wire logic crystal_or_clock_in,
   // Crystal drive
   output logic crystal_drive_out,
   // Differential pair 0
   output logic diff_clk0_true,
   output logic diff_clk0_comp,
   output logic diff_clk0_oe,
   // Differential pair 1
   output logic diff_clk1_true,
   output logic diff_clk1_comp,
   output logic diff_clk1_oe,
   // Differential pair 2
   output logic diff_clk2_true,
   output logic diff_clk2_comp,
   output logic diff_clk2_oe,
   // Differential pair 3
   output logic diff_clk3_true,
   output logic diff_clk3_comp,
   output logic diff_clk3_oe,
   // Single-ended reference output
   output logic ref_clk_out,
   output logic ref_clk_out_oe,
   output logic ref_clk_pulldown_en,
   // Spread modulation indicator
   output logic spread_active
);

   // Pin synchronisers, three stages each
   logic [2:0] pd_sync; // Reset pin stages
   logic [2:0] xtal_sync; // Crystal input stages
   logic pd_level; // Filtered reset pin level
   logic xtal_level; // Filtered crystal level
   logic xtal_prev; // Previous filtered crystal level
   logic xtal_rise; // One-cycle crystal rising edge
   logic pd_low; // Global reset asserted

   // Configuration and state
   logic [7:0] cfg0; // Output enables
   logic [7:0] cfg1; // Spread enable
   logic [7:0] lock_count; // Crystal edges since reset release
   logic [7:0] next_lock_count;
   ckc_pkg::ckc_pll_state_type pll_state;
   ckc_pkg::ckc_pll_state_type next_pll_state;
   logic pll_run; // PLL taken as running
   logic first_cycle; // High for the first cycle after power up

   // Decoded fields
   wire logic ref_en = cfg0[`CKC_REF_EN_BIT];
   wire logic [3:0] diff_en = cfg0[`CKC_DIFF_EN_MSB:`CKC_DIFF_EN_LSB];
   wire logic spread_en = cfg1[`CKC_SPREAD_EN_BIT];

   // APB decode
   wire logic setup_phase = psel & ~penable;
   wire logic access_phase = psel & penable;
   wire logic hit_cfg0 = (paddr == `CKC_CFG0_OFFSET);
   wire logic hit_cfg1 = (paddr == `CKC_CFG1_OFFSET);
   wire logic hit_status = (paddr == `CKC_STATUS_OFFSET);
   wire logic addr_ok = hit_cfg0 | hit_cfg1 | hit_status;
   wire logic wr_cfg0 = access_phase & pwrite & hit_cfg0;
   wire logic wr_cfg1 = access_phase & pwrite & hit_cfg1;

   // Zero-extends a register byte onto the 32-bit read bus
   function automatic logic [31:0] byte_word(input logic [7:0] b);
      return {24'h000000, b};
   endfunction

   // Read data selection
   wire logic [7:0] status_byte = {6'h00, pd_low, pll_run};
   wire logic [31:0] read_mux = hit_cfg0 ? byte_word(cfg0) :
                                hit_cfg1 ? byte_word(cfg1) :
                                hit_status ? byte_word(status_byte) : 32'h00000000;

   // Output selection
   wire logic [3:0] next_diff_oe = diff_en & {4{pll_run}};
   wire logic next_diff_level = xtal_level & pll_run;
   wire logic next_ref_oe = ~pd_low;
   wire logic next_ref_out = ref_en & pll_run & xtal_level;

   // Zero wait states: every access phase completes at once
   assign pready = 1'b1;

   // Reset pin synchroniser; the level moves when stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pd_sync <= 3'h0;
         pd_level <= 1'b0;
      end else begin
         pd_sync <= {pd_sync[1:0], global_powerdown_reset_n};
         if (pd_sync[1] == pd_sync[2]) begin
            pd_level <= pd_sync[2];
         end
      end
   end

   assign pd_low = ~pd_level;

   // Crystal synchroniser and edge detector
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xtal_sync <= 3'h0;
         xtal_level <= 1'b0;
         xtal_prev <= 1'b0;
      end else begin
         xtal_sync <= {xtal_sync[1:0], crystal_or_clock_in};
         if (xtal_sync[1] == xtal_sync[2]) begin
            xtal_level <= xtal_sync[2];
         end
         xtal_prev <= xtal_level;
      end
   end

   assign xtal_rise = xtal_level & ~xtal_prev;

   // Configuration registers; the reset pin forces defaults and blocks writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg0 <= `CKC_CFG0_RESET;
         cfg1 <= `CKC_CFG1_RESET;
      end else if (pd_low) begin
         cfg0 <= `CKC_CFG0_RESET;
         cfg1 <= `CKC_CFG1_RESET;
      end else begin
         if (wr_cfg0) begin
            cfg0 <= pwdata[7:0];
         end
         if (wr_cfg1) begin
            cfg1 <= pwdata[7:0];
         end
      end
   end

   // Read data and error captured in the setup cycle, shown in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setup_phase) begin
         prdata <= pwrite ? 32'h00000000 : read_mux;
         pslverr <= ~addr_ok;
      end
   end

   // PLL sequencing: off under reset, counts crystal edges, then runs
   always_comb begin
      next_pll_state = pll_state;
      next_lock_count = lock_count;
      case (pll_state)
         ckc_pkg::PLL_OFF: begin
            next_lock_count = 8'h00;
            if (!pd_low) begin
               next_pll_state = ckc_pkg::PLL_LOCKING;
            end
         end
         ckc_pkg::PLL_LOCKING: begin
            if (xtal_rise) begin
               next_lock_count = lock_count + 8'h01;
            end
            if (lock_count == `CKC_PLL_LOCK_EDGES) begin
               next_pll_state = ckc_pkg::PLL_RUN;
            end
         end
         ckc_pkg::PLL_RUN: begin
            next_pll_state = ckc_pkg::PLL_RUN;
         end
         default: begin
            next_pll_state = ckc_pkg::PLL_OFF;
         end
      endcase
      if (pd_low) begin
         next_pll_state = ckc_pkg::PLL_OFF;
      end
   end

   // PLL state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_state <= ckc_pkg::PLL_OFF;
         lock_count <= 8'h00;
      end else begin
         pll_state <= next_pll_state;
         lock_count <= next_lock_count;
      end
   end

   assign pll_run = (pll_state == ckc_pkg::PLL_RUN);

   // Power-up marker for the default check
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_cycle <= 1'b1;
      end else begin
         first_cycle <= 1'b0;
      end
   end

   // Differential outputs; disabled pairs release both pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {diff_clk3_oe, diff_clk2_oe, diff_clk1_oe, diff_clk0_oe} <= 4'h0;
         {diff_clk0_true, diff_clk1_true, diff_clk2_true, diff_clk3_true} <= 4'h0;
         {diff_clk0_comp, diff_clk1_comp, diff_clk2_comp, diff_clk3_comp} <= 4'h0;
      end else begin
         {diff_clk3_oe, diff_clk2_oe, diff_clk1_oe, diff_clk0_oe} <= next_diff_oe;
         {diff_clk3_true, diff_clk2_true, diff_clk1_true, diff_clk0_true} <= next_diff_oe & {4{next_diff_level}};
         {diff_clk3_comp, diff_clk2_comp, diff_clk1_comp, diff_clk0_comp} <= next_diff_oe & {4{~next_diff_level}};
      end
   end

   // Reference output, crystal drive and common spread indicator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_clk_out <= 1'b0;
         ref_clk_out_oe <= 1'b0;
         ref_clk_pulldown_en <= 1'b1;
         crystal_drive_out <= 1'b0;
         spread_active <= 1'b0;
      end else begin
         ref_clk_out <= next_ref_out & ~pd_low;
         ref_clk_out_oe <= next_ref_oe;
         ref_clk_pulldown_en <= pd_low;
         crystal_drive_out <= ~xtal_level & ~pd_low;
         spread_active <= spread_en & pll_run;
      end
   end

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Global reset seen as asserted
   sequence pd_hold_s;
      pd_low;
   endsequence

   // Global reset seen to release
   sequence pd_release_s;
      pd_low ##1 !pd_low;
   endsequence

   // Edge count complete while still locking
   sequence lock_done_s;
      pll_state == ckc_pkg::PLL_LOCKING && lock_count == `CKC_PLL_LOCK_EDGES && !pd_low;
   endsequence

   // Disabled pair 2 lets go of both pins
   a_diff_hiz_off: assert property (!diff_en[2] |=> !diff_clk2_oe && !diff_clk2_true && !diff_clk2_comp)
      else $error("Disabled differential pair not released");
   // Global reset stops the PLL and the pairs
   a_pd_outputs_off: assert property (pd_hold_s |=> !pll_run ##1 (next_diff_oe == 4'h0) && !diff_clk0_oe)
      else $error("Outputs still on under global reset");
   // Global reset restores the defaults
   a_pd_cfg_default: assert property (pd_hold_s |=> cfg0 == `CKC_CFG0_RESET && cfg1 == `CKC_CFG1_RESET)
      else $error("Configuration not returned to defaults");
   // Reference output only pulled down under global reset
   a_ref_pulled_down: assert property (pd_low |=> !ref_clk_out_oe && ref_clk_pulldown_en && !ref_clk_out)
      else $error("Reference output driven under global reset");
   // Reference output driven low when its bit is clear
   a_ref_driven_low: assert property (!pd_low && !ref_en |=> ref_clk_out_oe && !ref_clk_out)
      else $error("Reference output not driven low when disabled");
   // Spread off for all pairs once disabled
   a_spread_common: assert property (!spread_en |=> !spread_active)
      else $error("Spread active while disabled");
   // Spread on once enabled and the PLL runs
   a_spread_on: assert property (spread_en && pll_run |=> spread_active)
      else $error("Spread not active while enabled");
   // Each pair enable follows its written bit
   a_diff_write_each: assert property (wr_cfg0 && !pd_low |=> diff_en == $past(pwdata[4:1]))
      else $error("Differential enables not taken from write");
   // Defaults present in the first cycle after power up
   a_boot_default: assert property (first_cycle |-> cfg0 == `CKC_CFG0_RESET && cfg1 == `CKC_CFG1_RESET)
      else $error("Configuration not at default after power up");
   // Locking starts right after global reset release
   a_resume_lock: assert property (pd_release_s |=> pll_state == ckc_pkg::PLL_LOCKING)
      else $error("PLL did not start locking after global reset release");
   // Full edge count brings the PLL to running
   a_resume_run: assert property (lock_done_s |=> pll_run)
      else $error("PLL did not resume after global reset release");
   // Enabled pair 0 drives again once the PLL runs
   a_outputs_resume: assert property (pll_run && diff_en[0] |=> diff_clk0_oe)
      else $error("Enabled differential pair not driven after resume");

endmodule

// File: hw/ckc_regs.svh
// Register offsets, field positions, reset values and counts for the clock output control block
`ifndef CKC_REGS_SVH
`define CKC_REGS_SVH

// Register byte offsets on the APB bus
`define CKC_CFG0_OFFSET 12'h000
`define CKC_CFG1_OFFSET 12'h004
`define CKC_STATUS_OFFSET 12'h008

// Configuration byte 0: reference output enable and differential output enables
`define CKC_REF_EN_BIT 0
`define CKC_DIFF_EN_LSB 1
`define CKC_DIFF_EN_MSB 4
`define CKC_CFG0_RESET 8'h1F

// Configuration byte 1: spread modulation enable
`define CKC_SPREAD_EN_BIT 0
`define CKC_CFG1_RESET 8'h01

// Status fields
`define CKC_STAT_PLL_RUN_BIT 0
`define CKC_STAT_PD_LOW_BIT 1

// Crystal rising edges counted before the PLL is taken as running
`define CKC_PLL_LOCK_EDGES 8'h10

`endif

// File: hw/ckc_pkg.sv
// Types shared by the clock output control block
package ckc_pkg;

   // PLL sequencing states
   typedef enum logic [1:0] {
      PLL_OFF,
      PLL_LOCKING,
      PLL_RUN
   } ckc_pll_state_type;

endpackage

// File: tb/ckc_xtal_model.sv
// Free-running crystal stand-in that feeds the block's crystal input
`timescale 1ns/10ps
module ckc_xtal_model #(
   parameter int HALF_NS = 100
) (
   // Crystal level seen by the block
   output logic xtal
);
   // A crystal oscillates without pause, so no framing is needed
   initial begin
      xtal = 1'b0;
      #7;
      forever #(HALF_NS) xtal = ~xtal;
   end
endmodule

// File: tb/clock_output_enable_reset_control_test.sv
// Self-checking testbench for the clock output control block
`timescale 1ns/10ps
`include "ckc_regs.svh"
module clock_output_enable_reset_control_test;
   // Bench signals
   logic pclk, presetn, psel, penable, pwrite, pd_n, xtal;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, err, ref_o, ref_oe, pd_en, spr, xd;
   logic [3:0] t, c, oe;
   int num_errors = 0;
   int n_tests = 0;
   // One row: write, read back, expected data, error, pair enables, spread
   typedef struct {logic [11:0] a; logic [7:0] w; logic [7:0] r; logic e; logic [3:0] o; logic s;} ckc_row_type;
   ckc_row_type rows [5] = '{
      '{`CKC_CFG0_OFFSET, 8'h15, 8'h15, 1'b0, 4'hA, 1'b1},
      '{`CKC_CFG1_OFFSET, 8'h00, 8'h00, 1'b0, 4'hA, 1'b0},
      '{`CKC_CFG1_OFFSET, 8'h01, 8'h01, 1'b0, 4'hA, 1'b1},
      '{12'h00C, 8'hFF, 8'h00, 1'b1, 4'hA, 1'b1},
      '{`CKC_CFG0_OFFSET, 8'h1E, 8'h1E, 1'b0, 4'hF, 1'b1}};

   ckc_xtal_model XTAL (.xtal(xtal));

   ckc_clock_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .global_powerdown_reset_n(pd_n), .crystal_or_clock_in(xtal), .crystal_drive_out(xd),
      .diff_clk0_true(t[0]), .diff_clk0_comp(c[0]), .diff_clk0_oe(oe[0]),
      .diff_clk1_true(t[1]), .diff_clk1_comp(c[1]), .diff_clk1_oe(oe[1]),
      .diff_clk2_true(t[2]), .diff_clk2_comp(c[2]), .diff_clk2_oe(oe[2]),
      .diff_clk3_true(t[3]), .diff_clk3_comp(c[3]), .diff_clk3_oe(oe[3]),
      .ref_clk_out(ref_o), .ref_clk_out_oe(ref_oe), .ref_clk_pulldown_en(pd_en), .spread_active(spr));

   // Clock at 40 MHz
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // Counts, verdict and end of run
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Compare one value
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t got %0h expected %0h", $time, g, e);
      end
   endtask

   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 16) begin
         num_errors++;
         give_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Poll status until the PLL reports running
   task automatic wait_pll();
      int k;
      for (k = 0; k < 200; k++) begin
         apb(1'b0, `CKC_STATUS_OFFSET, 32'h0);
         if (rd[0] === 1'b1) break;
      end
      if (rd[0] !== 1'b1) begin
         num_errors++;
         give_verdict();
      end
   endtask

   // Main sequence
   initial begin
      int i, hi, lo;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pd_n = 1'b1;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `CKC_CFG0_OFFSET, 32'h0);
      chk(rd, {24'h0, `CKC_CFG0_RESET});
      apb(1'b0, `CKC_CFG1_OFFSET, 32'h0);
      chk(rd, {24'h0, `CKC_CFG1_RESET});
      wait_pll();
      // Reference output follows the crystal against the crystal drive; pairs keep true and complement apart
      hi = 0;
      lo = 0;
      repeat (40) begin
         @(negedge pclk);
         chk({28'h0, t ^ c}, {28'h0, oe});
         if (ref_o === 1'b1 && xd === 1'b0) hi++;
         if (ref_o === 1'b0 && xd === 1'b1) lo++;
      end
      chk({31'h0, (hi > 0) && (lo > 0)}, 32'h1);
      // Table of writes with read-back and pin checks
      for (i = 0; i < 5; i++) begin
         apb(1'b1, rows[i].a, {24'h0, rows[i].w});
         repeat (4) @(posedge pclk);
         apb(1'b0, rows[i].a, 32'h0);
         chk(rd, {24'h0, rows[i].r});
         chk({31'h0, err}, {31'h0, rows[i].e});
         chk({28'h0, oe}, {28'h0, rows[i].o});
         chk({28'h0, (t | c) & ~oe}, 32'h0);
         chk({31'h0, spr}, {31'h0, rows[i].s});
      end
      // Reference output disabled by its bit: driven low
      repeat (8) begin
         @(posedge pclk);
         chk({30'h0, ref_oe, ref_o}, 32'h2);
      end
      // Pin reset: all off, pull-down only, writes ignored
      pd_n <= 1'b0;
      repeat (8) @(posedge pclk);
      chk({18'h0, ref_oe, pd_en, oe, t, c}, 32'h1000);
      chk({31'h0, xd}, 32'h0);
      apb(1'b0, `CKC_STATUS_OFFSET, 32'h0);
      chk(rd, 32'h2);
      apb(1'b1, `CKC_CFG0_OFFSET, 32'h0);
      apb(1'b0, `CKC_CFG0_OFFSET, 32'h0);
      chk(rd, {24'h0, `CKC_CFG0_RESET});
      // Release: defaults resume once the PLL runs
      pd_n <= 1'b1;
      wait_pll();
      repeat (3) @(posedge pclk);
      chk({26'h0, ref_oe, oe, spr}, 32'h3F);
      // Mid-run register reset: outputs drop at once, written settings are lost
      apb(1'b1, `CKC_CFG1_OFFSET, 32'h0);
      presetn <= 1'b0;
      @(negedge pclk);
      chk({27'h0, oe, spr}, 32'h0);
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `CKC_CFG1_OFFSET, 32'h0);
      chk(rd, {24'h0, `CKC_CFG1_RESET});
      give_verdict();
   end
endmodule
